/* common/bfr_pkg.sv */
// shared constants and types for the burst and fault restart control unit
package bfr_pkg;
	// clock rate and documented times
	localparam longint CLK_HZ = 25_000_000; // system clock rate
	localparam longint BLANK_TIME_MS = 20; // basic blanking time
	localparam longint SPIKE_TIME_US = 30; // spike blanking after blank pin trip
	localparam longint OVP_TIME_US = 120; // high supply must persist this long
	localparam longint EXT_IGNORE_MS = 1; // external restart ignored after start-up
	// least times, rounded up to whole cycles
	localparam int BLANK_CYC = int'((BLANK_TIME_MS * CLK_HZ + 999) / 1000);
	localparam int SPIKE_CYC = int'((SPIKE_TIME_US * CLK_HZ + 999_999) / 1_000_000);
	localparam int OVP_CYC = int'((OVP_TIME_US * CLK_HZ + 999_999) / 1_000_000);
	localparam int EXT_IGN_CYC = int'((EXT_IGNORE_MS * CLK_HZ + 999) / 1000);
	localparam int CNT_W = 20; // wide enough for the blanking count
	typedef logic [CNT_W-1:0] bfr_cnt_t;
	// register map, byte addresses
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000; // control
	localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004; // live state
	localparam logic [ADDR_W-1:0] FAULT_OFS = 12'h008; // sticky fault causes
	localparam logic [31:0] CTRL_RST = 32'h0000_0001; // burst mode allowed
	localparam int CTRL_BURST_EN = 0; // control bit: burst mode allowed
	localparam int STAT_STATE_LSB = 0; // status: one-hot state
	localparam int STAT_OUT_LSB = 8; // status: control outputs
	// fault cause bit positions
	localparam int FLT_OVERLOAD = 0;
	localparam int FLT_SOFT_OVP = 1;
	localparam int FLT_RUN_OVP = 2;
	localparam int FLT_THERMAL = 3;
	localparam int FLT_EXT = 4;
	localparam int FLT_UNDERVOLT = 5;
	localparam int FLT_W = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control states, one-hot
	typedef enum logic [5:0] {
		ST_CHARGE = 6'h01, // startup cell charges supply
		ST_SOFT = 6'h02, // soft start
		ST_NORMAL = 6'h04, // normal regulation
		ST_BURST_OFF = 6'h08, // burst, bias off
		ST_BURST_ON = 6'h10, // burst, bias on
		ST_OFF = 6'h20 // auto-restart, waiting for supply to fall
	} bfr_state_e;
	// comparator decisions, all asynchronous to the clock
	typedef struct packed {
		logic low_load; // feedback below 1.22V
		logic burst_upper; // feedback above 3.6V
		logic burst_lower; // feedback at or below 3.1V
		logic overload; // feedback above 4.5V
		logic soft_ovp; // supply above 20.7V
		logic supply_ovp; // supply above 25.5V
		logic blank_level; // blanking pin at 4.0V
		logic ext_restart; // blanking pin below 0.33V
		logic thermal; // junction above 130C
		logic vcc_on; // supply at turn-on threshold
		logic vcc_off; // supply below turn-off threshold
	} bfr_cmp_s;
	// control outputs to the analog section
	typedef struct packed {
		logic bias_on; // internal bias enabled
		logic gate_en; // switching pulses allowed
		logic burst_flag; // burst mode active
		logic reduced_limit; // reduced 0.26V current limit selected
		logic clamp_release; // blanking pin clamp switch open
		logic startup_cell; // startup cell on
		logic soft_start; // soft start running
		logic restart; // auto-restart sequence active
	} bfr_out_s;
	localparam int OUT_W = 8;
endpackage

/* design/bfr_control.sv */
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// Overview of operation
// - blanking timer zero, counts when feedback low
// - burst entry after 20ms, feedback still low
// - burst, feedback above 3.6V restores bias
// - burst selects reduced 0.26V current limit
// - burst, feedback 3.1V pauses switching again
// - feedback above 4.5V leaves burst mode
// - every fault goes to auto-restart only
// - only overload uses extendable blanking
// - restart: cell on, off at turn-on
// - after soft start, recheck fault
// - overload 20ms then release clamp switch
// - blank pin 4.0V plus 30us triggers restart
// - soft start overvoltage with overload restarts
// - 25.5V for 120us restarts, not burst
// - overtemperature enters auto-restart
// - low blank pin stops gate, then restarts
// - external request ignored 1ms at start-up
// - undervoltage turns off, enables startup cell
// - feedback held low ends in undervoltage restart
module bfr_control #(
	parameter int P_BLANK_CYC = bfr_pkg::BLANK_CYC, // basic blanking cycles
	parameter int P_EXT_IGN_CYC = bfr_pkg::EXT_IGN_CYC // start-up ignore cycles
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_rst, // async reset, active high
	input wire logic i_ce, // clock enable, freezes all state when low
	input wire bfr_pkg::bfr_cmp_s i_cmp, // comparator decisions
	input wire logic i_soft_done, // soft start phase complete
	output bfr_pkg::bfr_out_s o_ctl, // control outputs
	input wire logic [11:0] i_awaddr, // write address
	input wire logic i_awvalid, // write address valid
	output logic o_awready, // write address ready
	input wire logic [31:0] i_wdata, // write data
	input wire logic [3:0] i_wstrb, // write strobes
	input wire logic i_wvalid, // write data valid
	output logic o_wready, // write data ready
	output logic [1:0] o_bresp, // write response
	output logic o_bvalid, // write response valid
	input wire logic i_bready, // write response ready
	input wire logic [11:0] i_araddr, // read address
	input wire logic i_arvalid, // read address valid
	output logic o_arready, // read address ready
	output logic [31:0] o_rdata, // read data
	output logic [1:0] o_rresp, // read response
	output logic o_rvalid, // read data valid
	input wire logic i_rready // read data ready
);
	// true in either burst state
	function automatic logic is_burst(input bfr_pkg::bfr_state_e st);
		is_burst = (st == bfr_pkg::ST_BURST_OFF) || (st == bfr_pkg::ST_BURST_ON);
	endfunction
	// saturating count while a condition holds, else back to zero
	function automatic bfr_pkg::bfr_cnt_t cnt_step(input bfr_pkg::bfr_cnt_t c, input logic en,
			input int lim);
		if (!en) begin
			cnt_step = '0;
		end else if (c >= lim[bfr_pkg::CNT_W-1:0]) begin
			cnt_step = c;
		end else begin
			cnt_step = c + bfr_pkg::CNT_W'(1);
		end
	endfunction
	// register address decode, shared by reads and writes
	function automatic logic is_mapped(input logic [11:0] a);
		if (a == bfr_pkg::CTRL_OFS) begin
			is_mapped = 1'b1;
		end else if (a == bfr_pkg::STAT_OFS) begin
			is_mapped = 1'b1;
		end else if (a == bfr_pkg::FAULT_OFS) begin
			is_mapped = 1'b1;
		end else begin
			is_mapped = 1'b0;
		end
	endfunction

	// comparator synchronisers
	bfr_pkg::bfr_cmp_s sync1_reg; // first stage, read only by second
	bfr_pkg::bfr_cmp_s sync2_reg; // usable comparator state
	bfr_pkg::bfr_cmp_s cmp; // alias of the second stage
	// control state
	bfr_pkg::bfr_state_e state_reg, state_next;
	bfr_pkg::bfr_cnt_t blank_reg, blank_next; // basic blanking timer
	bfr_pkg::bfr_cnt_t spike_reg, spike_next; // spike blanking timer
	bfr_pkg::bfr_cnt_t ovp_reg, ovp_next; // high supply persistence
	bfr_pkg::bfr_cnt_t ext_reg, ext_next; // external request persistence
	bfr_pkg::bfr_cnt_t ign_reg, ign_next; // start-up ignore timer
	logic clamp_reg, clamp_next; // clamp switch released
	bfr_pkg::bfr_out_s out_reg, out_next; // registered outputs
	// register file
	logic [31:0] ctrl_reg, ctrl_next;
	logic [bfr_pkg::FLT_W-1:0] flt_reg, flt_next; // sticky causes
	logic [bfr_pkg::FLT_W-1:0] flt_set; // causes seen this cycle
	logic [bfr_pkg::FLT_W-1:0] flt_clr; // software write-one-to-clear
	// decoded conditions
	logic run; // controller powered and switching capable
	logic blank_done, ign_done, ext_active;
	logic ovl_fault, soft_ovp_fault, run_ovp_fault, therm_fault, ext_fault, uv_fault;
	logic any_fault;

	assign cmp = sync2_reg;

	// two-stage sync of every analog decision
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else if (i_ce) begin
			sync1_reg <= i_cmp;
			sync2_reg <= sync1_reg;
		end
	end

	// fault detection and timers
	always_comb begin
		run = (state_reg == bfr_pkg::ST_SOFT) || (state_reg == bfr_pkg::ST_NORMAL) || is_burst(state_reg);
		blank_done = (blank_reg == P_BLANK_CYC[bfr_pkg::CNT_W-1:0]);
		ign_done = (ign_reg == P_EXT_IGN_CYC[bfr_pkg::CNT_W-1:0]);
		// request only counts once the start-up window has passed
		ext_active = run && cmp.ext_restart && ign_done;
		// timer runs only in normal regulation with low or high feedback; recovery clears it
		blank_next = cnt_step(blank_reg, (state_reg == bfr_pkg::ST_NORMAL)
			&& (cmp.low_load || cmp.overload), P_BLANK_CYC);
		// clamp opens once overload has outlasted the basic blanking
		clamp_next = (state_reg == bfr_pkg::ST_NORMAL) && cmp.overload
			&& (clamp_reg || blank_done);
		spike_next = cnt_step(spike_reg, clamp_reg && cmp.blank_level && cmp.overload,
			bfr_pkg::SPIKE_CYC);
		ovl_fault = clamp_reg && cmp.blank_level && cmp.overload
			&& (spike_reg >= bfr_pkg::CNT_W'(bfr_pkg::SPIKE_CYC - 1));
		// supply overvoltage check is blind in burst, where supply swings widely
		ovp_next = cnt_step(ovp_reg, run && !is_burst(state_reg) && cmp.supply_ovp,
			bfr_pkg::OVP_CYC);
		run_ovp_fault = run && !is_burst(state_reg) && cmp.supply_ovp
			&& (ovp_reg >= bfr_pkg::CNT_W'(bfr_pkg::OVP_CYC - 1));
		soft_ovp_fault = (state_reg == bfr_pkg::ST_SOFT) && cmp.soft_ovp && cmp.overload;
		therm_fault = run && cmp.thermal;
		// a persisting request must hold for the spike time, filtering short glitches
		ext_next = cnt_step(ext_reg, ext_active, bfr_pkg::SPIKE_CYC);
		ext_fault = ext_active && (ext_reg >= bfr_pkg::CNT_W'(bfr_pkg::SPIKE_CYC - 1));
		// undervoltage also catches a shorted feedback that stopped all switching
		uv_fault = run && cmp.vcc_off;
		any_fault = ovl_fault || soft_ovp_fault || run_ovp_fault || therm_fault
			|| ext_fault || uv_fault;
		// ignore window restarts on every charge phase
		ign_next = cnt_step(ign_reg, state_reg != bfr_pkg::ST_CHARGE, P_EXT_IGN_CYC);
		flt_set = '0;
		flt_set[bfr_pkg::FLT_OVERLOAD] = ovl_fault;
		flt_set[bfr_pkg::FLT_SOFT_OVP] = soft_ovp_fault;
		flt_set[bfr_pkg::FLT_RUN_OVP] = run_ovp_fault;
		flt_set[bfr_pkg::FLT_THERMAL] = therm_fault;
		flt_set[bfr_pkg::FLT_EXT] = ext_fault;
		flt_set[bfr_pkg::FLT_UNDERVOLT] = uv_fault;
	end

	// control state machine
	always_comb begin
		state_next = state_reg;
		if (run && any_fault) begin
			// every fault lands in the one auto-restart path
			state_next = uv_fault ? bfr_pkg::ST_CHARGE : bfr_pkg::ST_OFF;
		end else begin
			case (state_reg)
				bfr_pkg::ST_CHARGE: begin
					if (cmp.vcc_on) begin
						state_next = bfr_pkg::ST_SOFT;
					end
				end
				bfr_pkg::ST_SOFT: begin
					if (i_soft_done) begin
						// a fault still present sends it round again
						if (cmp.thermal || ext_active || cmp.supply_ovp) begin
							state_next = bfr_pkg::ST_OFF;
						end else begin
							state_next = bfr_pkg::ST_NORMAL;
						end
					end
				end
				bfr_pkg::ST_NORMAL: begin
					if (blank_done && cmp.low_load && ctrl_reg[bfr_pkg::CTRL_BURST_EN]) begin
						state_next = bfr_pkg::ST_BURST_OFF;
					end
				end
				bfr_pkg::ST_BURST_OFF: begin
					if (cmp.overload) begin
						state_next = bfr_pkg::ST_NORMAL;
					end else if (cmp.burst_upper) begin
						state_next = bfr_pkg::ST_BURST_ON;
					end
				end
				bfr_pkg::ST_BURST_ON: begin
					if (cmp.overload) begin
						state_next = bfr_pkg::ST_NORMAL;
					end else if (cmp.burst_lower) begin
						state_next = bfr_pkg::ST_BURST_OFF;
					end
				end
				bfr_pkg::ST_OFF: begin
					// no switching, so supply sags to turn-off
					if (cmp.vcc_off) begin
						state_next = bfr_pkg::ST_CHARGE;
					end
				end
				default: begin
					state_next = bfr_pkg::ST_CHARGE; // recover from an illegal code
				end
			endcase
		end
		// outputs follow the next state so they change with it
		out_next.bias_on = (state_next == bfr_pkg::ST_SOFT) || (state_next == bfr_pkg::ST_NORMAL)
			|| (state_next == bfr_pkg::ST_BURST_ON);
		out_next.gate_en = out_next.bias_on && !ext_active;
		out_next.burst_flag = is_burst(state_next);
		out_next.reduced_limit = is_burst(state_next);
		out_next.clamp_release = clamp_next && (state_next == bfr_pkg::ST_NORMAL);
		out_next.startup_cell = (state_next == bfr_pkg::ST_CHARGE);
		out_next.soft_start = (state_next == bfr_pkg::ST_SOFT);
		out_next.restart = (state_next == bfr_pkg::ST_OFF) || (state_next == bfr_pkg::ST_CHARGE);
	end

	// control registers; power-on starts by charging the supply
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= bfr_pkg::ST_CHARGE;
			blank_reg <= '0;
			spike_reg <= '0;
			ovp_reg <= '0;
			ext_reg <= '0;
			ign_reg <= '0;
			clamp_reg <= 1'b0;
			out_reg <= '0;
		end else if (i_ce) begin
			state_reg <= state_next;
			blank_reg <= blank_next;
			spike_reg <= spike_next;
			ovp_reg <= ovp_next;
			ext_reg <= ext_next;
			ign_reg <= ign_next;
			clamp_reg <= clamp_next;
			out_reg <= out_next;
		end
	end

	assign o_ctl = out_reg;

	// bus slave state
	logic aw_full_reg, aw_full_next; // write address held
	logic w_full_reg, w_full_next; // write data held
	logic [11:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic do_write; // both halves held, commit this cycle

	// readies drop while frozen so no beat is taken and then lost
	assign o_awready = i_ce && !aw_full_reg && !bvalid_reg;
	assign o_wready = i_ce && !w_full_reg && !bvalid_reg;
	assign o_arready = i_ce && !rvalid_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rresp = rresp_reg;
	assign o_rdata = rdata_reg;

	// bus next-state logic
	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		flt_clr = '0;
		// address and data may arrive in either order
		if (i_awvalid && o_awready) begin
			aw_full_next = 1'b1;
			awaddr_next = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			w_full_next = 1'b1;
			wdata_next = i_wdata;
			wstrb_next = i_wstrb;
		end
		do_write = aw_full_reg && w_full_reg && !bvalid_reg;
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = is_mapped(awaddr_reg) ? bfr_pkg::RESP_OKAY : bfr_pkg::RESP_SLVERR;
			if (awaddr_reg == bfr_pkg::CTRL_OFS) begin
				// only the low lane carries defined bits
				if (wstrb_reg[0]) begin
					ctrl_next = {31'h0000_0000, wdata_reg[bfr_pkg::CTRL_BURST_EN]};
				end
			end else if (awaddr_reg == bfr_pkg::FAULT_OFS) begin
				if (wstrb_reg[0]) begin
					flt_clr = wdata_reg[bfr_pkg::FLT_W-1:0];
				end
			end
		end else if (bvalid_reg && i_bready) begin
			bvalid_next = 1'b0;
		end
		// a cause seen in the same cycle as its clear stays set
		flt_next = (flt_reg & ~flt_clr) | flt_set;
		if (i_arvalid && o_arready) begin
			rvalid_next = 1'b1;
			rresp_next = is_mapped(i_araddr) ? bfr_pkg::RESP_OKAY : bfr_pkg::RESP_SLVERR;
			rdata_next = '0;
			if (i_araddr == bfr_pkg::CTRL_OFS) begin
				rdata_next = ctrl_reg;
			end else if (i_araddr == bfr_pkg::STAT_OFS) begin
				rdata_next[bfr_pkg::STAT_STATE_LSB +: 6] = state_reg;
				rdata_next[bfr_pkg::STAT_OUT_LSB +: bfr_pkg::OUT_W] = out_reg;
			end else if (i_araddr == bfr_pkg::FAULT_OFS) begin
				rdata_next[bfr_pkg::FLT_W-1:0] = flt_reg;
			end
		end else if (rvalid_reg && i_rready) begin
			rvalid_next = 1'b0;
		end
	end

	// bus registers
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= bfr_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= bfr_pkg::RESP_OKAY;
			rdata_reg <= '0;
			ctrl_reg <= bfr_pkg::CTRL_RST;
			flt_reg <= '0;
		end else if (i_ce) begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			flt_reg <= flt_next;
		end
	end

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	chk_blank_hold: assert property (i_ce && state_reg == bfr_pkg::ST_NORMAL
		&& !cmp.low_load && !cmp.overload |=> blank_reg == '0)
		else $error("blanking timer not cleared");
	chk_burst_entry: assert property (i_ce && state_reg == bfr_pkg::ST_NORMAL && !any_fault
		&& blank_done && cmp.low_load && ctrl_reg[bfr_pkg::CTRL_BURST_EN]
		|=> state_reg == bfr_pkg::ST_BURST_OFF && o_ctl.burst_flag && !o_ctl.bias_on)
		else $error("burst entry missed");
	chk_burst_guard: assert property ($rose(o_ctl.burst_flag) |-> $past(blank_done))
		else $error("burst entered before blanking");
	chk_burst_wake: assert property (i_ce && state_reg == bfr_pkg::ST_BURST_OFF && !any_fault
		&& !cmp.overload && cmp.burst_upper |=> o_ctl.bias_on && o_ctl.gate_en == !$past(ext_active))
		else $error("burst wake failed");
	chk_reduced_lim: assert property (o_ctl.reduced_limit == is_burst(state_reg))
		else $error("current limit selection wrong");
	chk_burst_pause: assert property (i_ce && state_reg == bfr_pkg::ST_BURST_ON && !any_fault
		&& !cmp.overload && cmp.burst_lower |=> !o_ctl.bias_on && !o_ctl.gate_en)
		else $error("burst pause failed");
	chk_burst_exit: assert property (i_ce && is_burst(state_reg) && cmp.overload
		|=> !o_ctl.burst_flag && !o_ctl.reduced_limit)
		else $error("burst exit failed");
	chk_spike_trip: assert property (i_ce && run && ovl_fault |=> o_ctl.restart && !o_ctl.bias_on
		&& $past(spike_reg) >= bfr_pkg::CNT_W'(bfr_pkg::SPIKE_CYC - 1))
		else $error("overload restart wrong");
	chk_ovp_burst: assert property (i_ce && is_burst(state_reg) |=> ovp_reg == '0)
		else $error("ovp timer ran in burst");
	chk_charge_cell: assert property (i_ce && state_reg == bfr_pkg::ST_OFF && cmp.vcc_off
		|=> o_ctl.startup_cell && !o_ctl.gate_en)
		else $error("startup cell not enabled");
	chk_ext_gate: assert property (ext_active && i_ce |=> !o_ctl.gate_en)
		else $error("gate not stopped on request");
endmodule // bfr_control

/* testbench/bfr_cmp_model.sv */
`timescale 1ns/10ps
// analog comparator stand-in; levels in mV, temperature in degC
module bfr_cmp_model #(
	parameter int P_VON_MV = 18000, // supply turn-on level, plain default
	parameter int P_VOFF_MV = 10500 // supply turn-off level
) (
	input var int i_fb_mv, // feedback level
	input var int i_vcc_mv, // supply level
	input var int i_ba_mv, // blanking pin level
	input var int i_temp_c, // junction temperature
	output bfr_pkg::bfr_cmp_s o_cmp // comparator decisions
);
	// bare level compares: no hysteresis here, so any filtering must come from the block itself
	always_comb begin
		o_cmp.low_load = i_fb_mv < 1220;
		o_cmp.burst_upper = i_fb_mv > 3600;
		o_cmp.burst_lower = i_fb_mv <= 3100;
		o_cmp.overload = i_fb_mv > 4500;
		o_cmp.soft_ovp = i_vcc_mv > 20700;
		o_cmp.supply_ovp = i_vcc_mv > 25500;
		o_cmp.blank_level = i_ba_mv >= 4000;
		o_cmp.ext_restart = i_ba_mv < 330;
		o_cmp.thermal = i_temp_c > 130;
		o_cmp.vcc_on = i_vcc_mv >= P_VON_MV;
		o_cmp.vcc_off = i_vcc_mv < P_VOFF_MV;
	end
endmodule // bfr_cmp_model

/* testbench/bfr_control_tb.sv */
`timescale 1ns/10ps
// reads are queued with their expectation; a monitor compares when data returns
module bfr_control_tb;
	logic i_clk_sys; // system clock
	logic i_rst; // reset
	logic soft_done; // soft start finished
	int fb_mv, vcc_mv, ba_mv, temp_c; // analog levels
	bfr_pkg::bfr_cmp_s cmp; // comparator decisions
	bfr_pkg::bfr_out_s ctl; // control outputs
	logic [11:0] awaddr, araddr; // bus addresses
	logic [31:0] wdata, rdata; // bus data
	logic awvalid, wvalid, bready, arvalid, rready; // master side
	logic awready, wready, bvalid, arready, rvalid; // slave side
	logic [1:0] bresp, rresp; // responses
	logic [65:0] exp_q[$]; // pending reads: resp, data, mask
	logic [65:0] q_head; // oldest note
	logic [31:0] seed = 32'h63cf95e8; // xorshift state
	int num_errors = 0; // mismatches
	int checks = 0; // comparisons
	bfr_cmp_model cmp_u (.i_fb_mv(fb_mv), .i_vcc_mv(vcc_mv), .i_ba_mv(ba_mv), .i_temp_c(temp_c), .o_cmp(cmp));
	// short counts keep the run brief
	bfr_control #(.P_BLANK_CYC(40), .P_EXT_IGN_CYC(20)) dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1),
		.i_cmp(cmp), .i_soft_done(soft_done), .o_ctl(ctl), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task tend(input string s);
		$display("test %s finished", s);
	endtask
	// supply sags to turn-off, charges back to turn-on, then soft start completes
	task boot();
		vcc_mv <= 9000;
		wt(6);
		vcc_mv <= 18000;
		wt(6);
		soft_done <= 1'b1;
		wt(6);
		soft_done <= 1'b0;
	endtask
	// one write; bready is held from the start, so the response is taken at the edge it is seen
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge i_clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// no cycle count assumed: only the watchdog ends a hung wait
		do begin
			@(posedge i_clk_sys);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {29'h0, 1'b1, er}, {29'h0, bvalid, bresp});
	endtask
	// one read; the note goes on the queue before the request
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
		exp_q.push_back({er, e, m});
		@(posedge i_clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge i_clk_sys);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	// monitor: the edge where rvalid and rready are both high carries the answer
	always @(posedge i_clk_sys) begin
		if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
			q_head = exp_q.pop_front();
			chk("rdata", q_head[63:32], rdata & q_head[31:0]);
			chk("rresp", {30'h0, q_head[65:64]}, {30'h0, rresp});
		end
	end
	task test_done();
		chk("pending reads", 32'h0, 32'(exp_q.size()));
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	// watchdog: the whole sequence needs well under 10000 cycles
	initial begin
		wt(20000);
		num_errors++;
		$display("unexpected watchdog: expected finish seen timeout");
		test_done();
	end
	initial begin
		i_rst = 1'b1;
		soft_done = 1'b0;
		fb_mv = 2500;
		vcc_mv = 9000;
		ba_mv = 900;
		temp_c = 25;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		wt(10);
		i_rst <= 1'b0;
		rd(bfr_pkg::STAT_OFS, 32'h0501, 32'hffff, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::CTRL_OFS, 32'h1, 32'h1, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::FAULT_OFS, 32'h0, 32'h3f, bfr_pkg::RESP_OKAY);
		rd(12'h00c, 32'h0, 32'hffffffff, bfr_pkg::RESP_SLVERR);
		wr(12'h010, xs(), bfr_pkg::RESP_SLVERR);
		tend("reset");
		vcc_mv <= 18000;
		wt(6);
		rd(bfr_pkg::STAT_OFS, 32'h0202, 32'h0203, bfr_pkg::RESP_OKAY);
		vcc_mv <= 15000;
		soft_done <= 1'b1;
		wt(6);
		soft_done <= 1'b0;
		rd(bfr_pkg::STAT_OFS, 32'hc004, 32'hffff, bfr_pkg::RESP_OKAY);
		tend("start");
		// a short dip must not carry its count into the next dip
		fb_mv <= 200 + int'(xs() % 32'd900);
		wt(25);
		fb_mv <= 2500;
		wt(10);
		fb_mv <= 1000;
		wt(25);
		rd(bfr_pkg::STAT_OFS, 32'hc004, 32'hffff, bfr_pkg::RESP_OKAY);
		wt(30);
		rd(bfr_pkg::STAT_OFS, 32'h3008, 32'hffff, bfr_pkg::RESP_OKAY);
		tend("burst entry");
		fb_mv <= 3800;
		wt(6);
		rd(bfr_pkg::STAT_OFS, 32'hf010, 32'hffff, bfr_pkg::RESP_OKAY);
		fb_mv <= 3000;
		wt(6);
		rd(bfr_pkg::STAT_OFS, 32'h3008, 32'hffff, bfr_pkg::RESP_OKAY);
		fb_mv <= 4700;
		wt(6);
		rd(bfr_pkg::STAT_OFS, 32'hc004, 32'hffff, bfr_pkg::RESP_OKAY);
		fb_mv <= 2500;
		tend("burst cycle");
		temp_c <= 140;
		wt(6);
		rd(bfr_pkg::STAT_OFS, 32'h0120, 32'h013f, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::FAULT_OFS, 32'h08, 32'h08, bfr_pkg::RESP_OKAY);
		chk("ctl", 32'h01, 32'(ctl));
		temp_c <= 25;
		wr(bfr_pkg::FAULT_OFS, 32'h3f, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::FAULT_OFS, 32'h0, 32'h3f, bfr_pkg::RESP_OKAY);
		vcc_mv <= 9000;
		wt(6);
		rd(bfr_pkg::STAT_OFS, 32'h0401, 32'h043f, bfr_pkg::RESP_OKAY);
		tend("restart");
		boot();
		// overload outlasts the basic blanking, opens the clamp, then the blank pin trips
		fb_mv <= 4700;
		wt(45);
		rd(bfr_pkg::STAT_OFS, 32'hc804, 32'hffff, bfr_pkg::RESP_OKAY);
		ba_mv <= 4200;
		wt(800);
		rd(bfr_pkg::STAT_OFS, 32'h0120, 32'hffff, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::FAULT_OFS, 32'h01, 32'h3f, bfr_pkg::RESP_OKAY);
		fb_mv <= 2500;
		ba_mv <= 900;
		wr(bfr_pkg::FAULT_OFS, 32'h3f, bfr_pkg::RESP_OKAY);
		tend("overload");
		boot();
		wt(20);
		// a low blank pin stops the gate at once, and restarts only once it has persisted
		ba_mv <= 200;
		wt(6);
		rd(bfr_pkg::STAT_OFS, 32'h8004, 32'hffff, bfr_pkg::RESP_OKAY);
		wt(800);
		rd(bfr_pkg::STAT_OFS, 32'h0120, 32'hffff, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::FAULT_OFS, 32'h10, 32'h3f, bfr_pkg::RESP_OKAY);
		ba_mv <= 900;
		wr(bfr_pkg::FAULT_OFS, 32'h3f, bfr_pkg::RESP_OKAY);
		tend("external restart");
		boot();
		// high supply just short of the persistence time, then past it
		vcc_mv <= 26000;
		wt(2950);
		rd(bfr_pkg::STAT_OFS, 32'h04, 32'h3f, bfr_pkg::RESP_OKAY);
		wt(100);
		rd(bfr_pkg::STAT_OFS, 32'h20, 32'h3f, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::FAULT_OFS, 32'h04, 32'h04, bfr_pkg::RESP_OKAY);
		tend("supply overvoltage");
		// overvoltage together with overload during soft start restarts at once
		fb_mv <= 4700;
		vcc_mv <= 9000;
		wt(6);
		vcc_mv <= 22000;
		wt(8);
		rd(bfr_pkg::STAT_OFS, 32'h0120, 32'hffff, bfr_pkg::RESP_OKAY);
		rd(bfr_pkg::FAULT_OFS, 32'h06, 32'h3f, bfr_pkg::RESP_OKAY);
		tend("soft start overvoltage");
		wt(4);
		test_done();
	end
endmodule // bfr_control_tb
